// *** src/edc_pkg.sv ***
/*
 * Constants, timing figures and carrier types for the page-mode DRAM controller.
 * Assumes a 25 MHz system clock and a 4M x 16 multiplexed-address DRAM on the pins.
 */
package edc_pkg;
	localparam int ROW_BITS = 12;
	localparam int COL_BITS = 10;
	localparam int DATA_BITS = 16;
	localparam int CLK_MHZ = 25;
	localparam int CLK_PERIOD_NS = 40;
	// Timing figures in their own units
	localparam int ROW_ACTIVE_MIN_NS = 50;
	localparam int ROW_PRECHARGE_MIN_NS = 30;
	localparam int COL_PRECHARGE_MIN_NS = 8;
	localparam int ROW_ACCESS_TIME_NS = 50;
	localparam int COL_ADDR_ACCESS_TIME_NS = 25;
	localparam int OUTPUT_ENABLE_ACCESS_TIME_NS = 13;
	localparam int POWER_UP_WAIT_US = 200;
	localparam int REFRESH_PERIOD_MS = 64;
	localparam int REFRESH_ROWS = 4096;
	localparam int INIT_PULSES = 8;
	// Least times round up, never under one cycle
	function automatic int ceil_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : ceil_cyc
	localparam int ROW_ACTIVE_CYC = ceil_cyc(ROW_ACTIVE_MIN_NS);
	localparam int ROW_PRE_CYC = ceil_cyc(ROW_PRECHARGE_MIN_NS);
	localparam int COL_PRE_CYC = ceil_cyc(COL_PRECHARGE_MIN_NS);
	localparam int COL_ACCESS_CYC = ceil_cyc(COL_ADDR_ACCESS_TIME_NS);
	localparam int OE_ACCESS_CYC = ceil_cyc(OUTPUT_ENABLE_ACCESS_TIME_NS);
	localparam int ROW_ACCESS_CYC = ceil_cyc(ROW_ACCESS_TIME_NS);
	localparam int POWER_UP_CYC = POWER_UP_WAIT_US * CLK_MHZ;
	// Longest refresh spacing rounds down
	localparam int REFRESH_INTERVAL_CYC = (REFRESH_PERIOD_MS * 1000 * CLK_MHZ) / REFRESH_ROWS;
	localparam int TIMER_BITS = 16;
	localparam logic [1:0] LANE_BOTH = 2'h3;
	typedef enum logic [1:0] {
		EDC_OP_READ = 2'h0,
		EDC_OP_WRITE = 2'h1,
		EDC_OP_RMW = 2'h2
	} edc_op_t;
	// User request carrier
	typedef struct packed {
		edc_op_t op;
		logic [ROW_BITS-1:0] row;
		logic [COL_BITS-1:0] col;
		logic [1:0] lanes;
		logic [DATA_BITS-1:0] wdata;
		logic last;
	} edc_req_t;
	// DRAM pin carrier, all strobes active low
	typedef struct packed {
		logic row_strobe_n;
		logic lower_col_strobe_n;
		logic upper_col_strobe_n;
		logic write_enable_n;
		logic output_enable_n;
		logic [ROW_BITS-1:0] mux_address;
	} edc_pins_t;
endpackage : edc_pkg

// *** src/edc_timer.sv ***
/*
 * Load-and-count-down timer with a done level.
 * Assumes one system clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ns
module edc_timer #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [WIDTH-1:0] value,
	output logic done
);
	logic [WIDTH-1:0] count;
	// Count down to zero after a load
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else if (load) begin
			count <= value;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end
	assign done = (count == '0) && !load;
endmodule : edc_timer

// *** src/edc_controller.sv ***
/*
 * Host-side controller for a multiplexed-address page-mode DRAM: power-up
 * sequence, periodic column-first refresh, page-mode read, write and read-write.
 * Assumes the DRAM data lines are resolved outside from DQ_OUT/DQ_OE.
 */
`timescale 1ns/1ns
module edc_controller #(
	parameter int POWER_UP_CYCLES = edc_pkg::POWER_UP_CYC,
	parameter int REFRESH_INTERVAL = edc_pkg::REFRESH_INTERVAL_CYC
) (
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic REQ_VALID,
	input wire edc_pkg::edc_req_t REQ,
	output logic REQ_READY,
	output logic RD_VALID,
	output logic [edc_pkg::DATA_BITS-1:0] RD_DATA,
	output logic INIT_DONE,
	output edc_pkg::edc_pins_t PINS,
	output logic [edc_pkg::DATA_BITS-1:0] DQ_OUT,
	output logic [1:0] DQ_OE,
	input wire logic [edc_pkg::DATA_BITS-1:0] DQ_IN
);
	typedef enum logic [9:0] {
		S_POWER = 10'h001,
		S_IDLE = 10'h002,
		S_PRE = 10'h004,
		S_RAS = 10'h008,
		S_CAS = 10'h010,
		S_WRITE = 10'h020,
		S_CASUP = 10'h040,
		S_REFC = 10'h080,
		S_REFR = 10'h100,
		S_ROWUP = 10'h200
	} edc_state_t;
	edc_state_t state;
	edc_pkg::edc_req_t cur;
	logic timer_load;
	logic [edc_pkg::TIMER_BITS-1:0] timer_value;
	logic timer_done;
	logic row_timer_load;
	logic row_done;
	logic [19:0] ref_count;
	logic ref_due;
	logic [3:0] init_left;
	logic refreshing;
	logic page_open;
	logic [$clog2(edc_pkg::ROW_ACCESS_CYC+2)-1:0] since_row;
	logic [edc_pkg::ROW_BITS-1:0] open_row;
	logic rmw_phase;
	logic col_ready;
	logic [3:0] row_falls_seen;
	localparam logic [edc_pkg::TIMER_BITS-1:0] PRE_CYC =
		edc_pkg::TIMER_BITS'(edc_pkg::ROW_PRE_CYC);
	localparam logic [edc_pkg::TIMER_BITS-1:0] ACT_CYC =
		edc_pkg::TIMER_BITS'(edc_pkg::ROW_ACTIVE_CYC);
	localparam logic [edc_pkg::TIMER_BITS-1:0] CAS_CYC =
		edc_pkg::TIMER_BITS'(edc_pkg::COL_ACCESS_CYC > edc_pkg::OE_ACCESS_CYC ?
		edc_pkg::COL_ACCESS_CYC : edc_pkg::OE_ACCESS_CYC);
	localparam logic [edc_pkg::TIMER_BITS-1:0] CPRE_CYC =
		edc_pkg::TIMER_BITS'(edc_pkg::COL_PRE_CYC);
	localparam logic [3:0] INIT_N = 4'(edc_pkg::INIT_PULSES);
	localparam logic [19:0] REF_N = 20'(REFRESH_INTERVAL);
	localparam logic [19:0] PWR_N = 20'(POWER_UP_CYCLES);

	// Step timer for precharge, column access and column precharge
	edc_timer #(.WIDTH(edc_pkg::TIMER_BITS)) u_step (
		.clk(CLK_SYS),
		.rst_n(RSTN),
		.load(timer_load),
		.value(timer_value),
		.done(timer_done)
	);
	// Row-active minimum timer, restarted on each row strobe fall
	edc_timer #(.WIDTH(edc_pkg::TIMER_BITS)) u_row (
		.clk(CLK_SYS),
		.rst_n(RSTN),
		.load(row_timer_load),
		.value(ACT_CYC),
		.done(row_done)
	);
	// Row strobe falls on leaving either of these states
	assign row_timer_load = (state == S_RAS) || (state == S_REFC);

	// Refresh interval counter; power-up wait reuses it
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			ref_count <= '0;
			ref_due <= 1'b0;
		end else begin
			if (state == S_POWER && init_left == INIT_N) begin
				ref_count <= (ref_count == PWR_N) ? 20'h00000 : ref_count + 20'h00001;
				ref_due <= (ref_count == PWR_N);
			end else if (ref_count >= REF_N - 20'h00001) begin
				ref_count <= 20'h00000;
				ref_due <= 1'b1;
			end else begin
				ref_count <= ref_count + 20'h00001;
				if (state == S_REFR && row_done)
					ref_due <= 1'b0; // Served refresh clears it
			end
		end
	end

	// Cycles since the row strobe fell, for row access time
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			since_row <= '0;
		end else if (PINS.row_strobe_n) begin
			since_row <= '0;
		end else if (since_row != '1) begin
			since_row <= since_row + 1'b1;
		end
	end

	assign REQ_READY = (state == S_IDLE) && INIT_DONE && !ref_due;
	assign refreshing = (state == S_REFC) || (state == S_REFR);

	// Sequencer: one-hot, strobes updated with state
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			state <= S_POWER;
			PINS <= '{row_strobe_n: 1'b1, lower_col_strobe_n: 1'b1,
				upper_col_strobe_n: 1'b1, write_enable_n: 1'b1,
				output_enable_n: 1'b1, mux_address: '0};
			DQ_OUT <= '0;
			DQ_OE <= 2'h0;
			cur <= '0;
			INIT_DONE <= 1'b0;
			init_left <= INIT_N;
			page_open <= 1'b0;
			open_row <= '0;
			rmw_phase <= 1'b0;
			col_ready <= 1'b0;
			RD_VALID <= 1'b0;
			RD_DATA <= '0;
			timer_load <= 1'b0;
			timer_value <= '0;
		end else begin
			timer_load <= 1'b0;
			RD_VALID <= 1'b0;
			unique case (state)
				S_POWER: begin
					// Wait, then eight column-first refreshes as init pulses
					if (ref_due) begin
						state <= S_PRE;
						timer_load <= 1'b1;
						timer_value <= PRE_CYC;
					end
				end
				S_IDLE: begin
					if ((ref_due || init_left != 4'h0) && !page_open) begin
						// Column-first refresh: column strobes low before row falls
						// Open page is shut first, else this would be a column access
						PINS.lower_col_strobe_n <= 1'b0;
						PINS.upper_col_strobe_n <= 1'b0;
						PINS.write_enable_n <= 1'b1;
						state <= S_REFC;
					end else if (REQ_VALID && REQ_READY) begin
						cur <= REQ;
						if (page_open && REQ.row == open_row) begin
							state <= S_CAS;
						end else begin
							PINS.mux_address <= REQ.row;
							state <= S_RAS;
						end
					end else if (page_open && row_done) begin
						PINS.row_strobe_n <= 1'b1; // Close idle page
						page_open <= 1'b0;
						timer_load <= 1'b1;
						timer_value <= PRE_CYC;
						state <= S_PRE;
					end
				end
				S_PRE: begin
					if (timer_done) begin
						state <= S_IDLE;
					end
				end
				S_RAS: begin
					PINS.row_strobe_n <= 1'b0;
					open_row <= cur.row;
					page_open <= 1'b1;
					state <= S_CAS;
				end
				S_CAS: begin
					// Column address on pins, then the strobes of the enabled lanes fall together
					// Flag, not address compare: a repeated column still sets up
					if (!col_ready) begin
						col_ready <= 1'b1;
						PINS.mux_address <= {2'h0, cur.col};
						PINS.write_enable_n <= (cur.op != edc_pkg::EDC_OP_WRITE);
						PINS.output_enable_n <= (cur.op == edc_pkg::EDC_OP_WRITE);
						DQ_OUT <= cur.wdata;
						DQ_OE <= (cur.op == edc_pkg::EDC_OP_WRITE) ? cur.lanes : 2'h0;
						rmw_phase <= 1'b0;
					end else begin
						PINS.lower_col_strobe_n <= !cur.lanes[0];
						PINS.upper_col_strobe_n <= !cur.lanes[1];
						col_ready <= 1'b0;
						timer_load <= 1'b1;
						timer_value <= CAS_CYC;
						state <= S_WRITE;
					end
				end
				S_WRITE: begin
					// Sample read data after every access time has run
					if (timer_done && since_row >= edc_pkg::ROW_ACCESS_CYC) begin
						if (cur.op != edc_pkg::EDC_OP_WRITE && !rmw_phase) begin
							RD_DATA <= DQ_IN;
							RD_VALID <= 1'b1;
						end
						if (cur.op == edc_pkg::EDC_OP_RMW && !rmw_phase) begin
							PINS.output_enable_n <= 1'b1;
							DQ_OE <= cur.lanes;
							rmw_phase <= 1'b1;
						end else if (rmw_phase && PINS.write_enable_n) begin
							PINS.write_enable_n <= 1'b0;
							timer_load <= 1'b1;
							timer_value <= CAS_CYC;
						end else begin
							PINS.lower_col_strobe_n <= 1'b1;
							PINS.upper_col_strobe_n <= 1'b1;
							timer_load <= 1'b1;
							timer_value <= CPRE_CYC;
							state <= S_CASUP;
						end
					end
				end
				S_CASUP: begin
					// Column precharge, then keep or close the page
					if (timer_done) begin
						DQ_OE <= 2'h0;
						PINS.write_enable_n <= 1'b1;
						PINS.output_enable_n <= 1'b1;
						if (cur.last || ref_due) begin
							state <= S_ROWUP;
						end else begin
							state <= S_IDLE;
						end
					end
				end
				S_ROWUP: begin
					if (row_done) begin
						PINS.row_strobe_n <= 1'b1;
						page_open <= 1'b0;
						timer_load <= 1'b1;
						timer_value <= PRE_CYC;
						state <= S_PRE;
					end
				end
				S_REFC: begin
					PINS.row_strobe_n <= 1'b0;
					state <= S_REFR;
				end
				S_REFR: begin
					if (row_done && !PINS.row_strobe_n) begin
						PINS.row_strobe_n <= 1'b1;
						PINS.lower_col_strobe_n <= 1'b1;
						PINS.upper_col_strobe_n <= 1'b1;
						// Each init pulse counted as it ends
						if (init_left != 4'h0)
							init_left <= init_left - 4'h1;
						if (init_left == 4'h1)
							INIT_DONE <= 1'b1;
						timer_load <= 1'b1;
						timer_value <= PRE_CYC;
						state <= S_PRE;
					end
				end
			endcase
		end
	end

	// All strobes high: write data released
	property p_standby_idle;
		@(posedge CLK_SYS) disable iff (!RSTN)
		(PINS.row_strobe_n && PINS.lower_col_strobe_n && PINS.upper_col_strobe_n)
			|-> DQ_OE == 2'h0;
	endproperty
	a_standby_idle: assert property (p_standby_idle) else $error("data driven in standby");
	property p_row_min;
		@(posedge CLK_SYS) disable iff (!RSTN)
		$fell(PINS.row_strobe_n) |-> !PINS.row_strobe_n [*2];
	endproperty
	a_row_min: assert property (p_row_min) else $error("row strobe too short");
	property p_precharge;
		@(posedge CLK_SYS) disable iff (!RSTN)
		$rose(PINS.row_strobe_n) |=> PINS.row_strobe_n;
	endproperty
	a_precharge: assert property (p_precharge) else $error("precharge too short");
	sequence s_cols_low;
		!PINS.lower_col_strobe_n || !PINS.upper_col_strobe_n;
	endsequence
	property p_refresh_order;
		@(posedge CLK_SYS) disable iff (!RSTN)
		($fell(PINS.row_strobe_n) && state == S_REFR) |-> s_cols_low;
	endproperty
	a_refresh_order: assert property (p_refresh_order) else $error("refresh order");
	property p_write_data;
		@(posedge CLK_SYS) disable iff (!RSTN)
		$fell(PINS.write_enable_n) |-> DQ_OE != 2'h0;
	endproperty
	a_write_data: assert property (p_write_data) else $error("write data absent");
	property p_lane_only;
		@(posedge CLK_SYS) disable iff (!RSTN)
		(state == S_WRITE && cur.op == edc_pkg::EDC_OP_WRITE)
			|-> PINS.lower_col_strobe_n == !cur.lanes[0];
	endproperty
	a_lane_only: assert property (p_lane_only) else $error("wrong lane strobe");
	property p_read_oe;
		@(posedge CLK_SYS) disable iff (!RSTN)
		RD_VALID |-> $past(PINS.write_enable_n) && !$past(PINS.output_enable_n);
	endproperty
	a_read_oe: assert property (p_read_oe) else $error("read without enables");
	// Row pulses seen on the pin, counted apart from the sequencer's count
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			row_falls_seen <= '0;
		end else if ($fell(PINS.row_strobe_n) && row_falls_seen != '1) begin
			row_falls_seen <= row_falls_seen + 4'h1;
		end
	end
	property p_ready_init;
		@(posedge CLK_SYS) disable iff (!RSTN)
		REQ_READY |-> INIT_DONE && row_falls_seen >= INIT_N;
	endproperty
	a_ready_init: assert property (p_ready_init) else $error("ready before init");
endmodule : edc_controller

// *** test/edc_dram_model.sv ***
/*
 * Behavioural page-mode DRAM seen from the controller's pins.
 * Assumes active-low strobes and one 16-bit word per row/column pair.
 */
`timescale 1ns/1ns
module edc_dram_model (
	input wire edc_pkg::edc_pins_t pins,
	input wire logic [15:0] dq_out,
	input wire logic [1:0] dq_oe,
	output logic [15:0] dq_in,
	output int ras_falls,
	output int cbr_count,
	output int violations
);
	logic [15:0] mem [int];
	logic [11:0] row;
	logic [9:0] col;
	logic [15:0] dout;
	logic [15:0] w;
	logic [1:0] lane_on;
	logic col_before_row_refresh;
	logic cas_open;
	logic [11:0] refresh_row;
	time t_ras, t_rise, t_cas, t_cup, t_oe;
	wire cas_n = pins.lower_col_strobe_n & pins.upper_col_strobe_n;
	// Everything quiet before the first strobe
	initial begin
		{ras_falls, cbr_count, violations} = '0;
		{t_ras, t_rise, t_cas, t_cup, t_oe} = '0;
		{lane_on, col_before_row_refresh, cas_open, refresh_row, dq_in, dout} = '0;
	end
	// Row fall: a low column strobe here means internal refresh
	always @(negedge pins.row_strobe_n) begin
		ras_falls++;
		if ($time - t_rise < edc_pkg::ROW_PRECHARGE_MIN_NS) violations++;
		t_ras = $time;
		col_before_row_refresh = !cas_n;
		if (col_before_row_refresh) begin
			cbr_count++;
			refresh_row = refresh_row + 12'h001;
		end else begin
			row = pins.mux_address;
		end
	end
	// Short row pulses corrupt cells, so they are counted as faults
	always @(posedge pins.row_strobe_n) begin
		if (ras_falls > 0 && $time - t_ras < edc_pkg::ROW_ACTIVE_MIN_NS) violations++;
		t_rise = $time;
	end
	always @(posedge cas_n) begin
		cas_open = 1'b0;
		t_cup = $time;
	end
	always @(negedge pins.output_enable_n) t_oe = $time;
	// Column latch on the first fall, write at the later of strobe and write enable
	always @(negedge cas_n or negedge pins.write_enable_n) begin
		if (!pins.row_strobe_n && !col_before_row_refresh && !cas_n) begin
			if (!cas_open) begin
				if ($time - t_cup < edc_pkg::COL_PRECHARGE_MIN_NS) violations++;
				col = pins.mux_address[9:0];
				t_cas = $time;
				dout = mem.exists({row, col}) ? mem[{row, col}] : {row[5:0], col};
				lane_on = ~{pins.upper_col_strobe_n, pins.lower_col_strobe_n};
				cas_open = 1'b1;
			end
			if (!pins.write_enable_n) begin
				w = mem.exists({row, col}) ? mem[{row, col}] : {row[5:0], col};
				if (lane_on[0]) w[7:0] = dq_out[7:0];
				if (lane_on[1]) w[15:8] = dq_out[15:8];
				if ((dq_oe & lane_on) != lane_on) violations++;
				mem[{row, col}] = w;
			end
		end
	end
	// Lanes drive only after all access times; idle lanes show a moving pattern
	always #1 begin
		if (pins.row_strobe_n && cas_n) lane_on = 2'b00;
		for (int i = 0; i < 2; i++) begin
			if (lane_on[i] && pins.write_enable_n && !pins.output_enable_n) begin
				if (dq_oe[i]) violations++;
				if ($time >= t_ras + edc_pkg::ROW_ACCESS_TIME_NS
					&& $time >= t_cas + edc_pkg::COL_ADDR_ACCESS_TIME_NS
					&& $time >= t_oe + edc_pkg::OUTPUT_ENABLE_ACCESS_TIME_NS) begin
					dq_in[i*8 +: 8] = dout[i*8 +: 8];
				end else begin
					dq_in[i*8 +: 8] = ~dq_in[i*8 +: 8];
				end
			end else begin
				dq_in[i*8 +: 8] = dq_oe[i] ? dq_out[i*8 +: 8] : ~dq_in[i*8 +: 8];
			end
		end
	end
endmodule : edc_dram_model

// *** test/edc_controller_tb_top.sv ***
/*
 * Self-checking bench for the page-mode DRAM controller against a DRAM model.
 * Assumes short power-up and refresh parameters set at the instance below.
 */
`timescale 1ns/1ns
module edc_controller_tb_top;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic req_valid = 1'b0;
	edc_pkg::edc_req_t req = '0;
	logic req_ready, rd_valid, init_done;
	logic [15:0] rd_data, dq_out, dq_in, rd;
	logic [1:0] dq_oe;
	edc_pkg::edc_pins_t pins;
	int ras_falls, cbr_count, violations;
	int fail_count = 0;
	int samples_checked = 0;
	// 25 MHz system clock
	always #20 clk_sys = ~clk_sys;
	edc_controller #(.POWER_UP_CYCLES(20), .REFRESH_INTERVAL(60)) dut_u (.CLK_SYS(clk_sys),
		.RSTN(rstn), .REQ_VALID(req_valid), .REQ(req), .REQ_READY(req_ready),
		.RD_VALID(rd_valid), .RD_DATA(rd_data), .INIT_DONE(init_done), .PINS(pins),
		.DQ_OUT(dq_out), .DQ_OE(dq_oe), .DQ_IN(dq_in));
	edc_dram_model dram_u (.pins(pins), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
		.ras_falls(ras_falls), .cbr_count(cbr_count), .violations(violations));
	task automatic end_of_test();
		if (fail_count == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_of_test
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	task automatic chk_min(input string what, input int lo, input int got);
		samples_checked++;
		if (got < lo) begin
			fail_count++;
			$display("unexpected %s: expected at least %0d, seen %0d", what, lo, got);
		end
	endtask : chk_min
	task automatic hang(input string what);
		fail_count++;
		$display("unexpected %s: expected completion, seen timeout", what);
		end_of_test();
	endtask : hang
	// Request held from a falling edge until the rising edge that takes it
	task automatic rq(input edc_pkg::edc_op_t op, input logic [11:0] r, input logic [9:0] c,
		input logic [1:0] ln, input logic [15:0] wd, input logic lst);
		int n;
		n = 0;
		@(negedge clk_sys);
		req = '{op: op, row: r, col: c, lanes: ln, wdata: wd, last: lst};
		req_valid = 1'b1;
		#1;
		while (req_ready !== 1'b1) begin
			@(negedge clk_sys);
			#1;
			n++;
			if (n > 500) hang("request taken");
		end
		@(negedge clk_sys);
		req_valid = 1'b0;
		n = 0;
		while (op != edc_pkg::EDC_OP_WRITE && rd_valid !== 1'b1) begin
			@(negedge clk_sys);
			n++;
			if (n > 50) hang("read answer");
		end
		rd = rd_data;
	endtask : rq
	task automatic t_reset();
		chk("reset pins", 16'h0070, {9'h000, pins.row_strobe_n, pins.lower_col_strobe_n,
			pins.upper_col_strobe_n, init_done, req_ready, dq_oe});
	endtask : t_reset
	task automatic t_init();
		int n;
		n = 0;
		while (init_done !== 1'b1) begin
			@(negedge clk_sys);
			n++;
			if (n > 1000) hang("initialisation");
		end
		chk_min("power-up wait", 20, n);
		chk_min("init row pulses", 8, ras_falls);
	endtask : t_init
	// Page writes and reads at both column ends of one row
	task automatic t_page();
		rq(edc_pkg::EDC_OP_WRITE, 12'h123, 10'h000, 2'h3, 16'hA5C3, 1'b0);
		rq(edc_pkg::EDC_OP_WRITE, 12'h123, 10'h3FF, 2'h3, 16'h3C5A, 1'b0);
		rq(edc_pkg::EDC_OP_READ, 12'h123, 10'h000, 2'h3, 16'h0000, 1'b0);
		chk("page read col 0", 16'hA5C3, rd);
		rq(edc_pkg::EDC_OP_READ, 12'h123, 10'h3FF, 2'h3, 16'h0000, 1'b1);
		chk("page read col 3FF", 16'h3C5A, rd);
	endtask : t_page
	// Same column in the highest and lowest rows must not alias
	task automatic t_rows();
		rq(edc_pkg::EDC_OP_WRITE, 12'hFFF, 10'h3FF, 2'h3, 16'h0F0F, 1'b1);
		rq(edc_pkg::EDC_OP_WRITE, 12'h000, 10'h3FF, 2'h3, 16'hF0F0, 1'b1);
		rq(edc_pkg::EDC_OP_READ, 12'hFFF, 10'h3FF, 2'h3, 16'h0000, 1'b1);
		chk("row FFF", 16'h0F0F, rd);
		rq(edc_pkg::EDC_OP_READ, 12'h000, 10'h3FF, 2'h3, 16'h0000, 1'b1);
		chk("row 000", 16'hF0F0, rd);
	endtask : t_rows
	task automatic t_bytes();
		rq(edc_pkg::EDC_OP_WRITE, 12'h055, 10'h100, 2'h3, 16'h1111, 1'b0);
		rq(edc_pkg::EDC_OP_WRITE, 12'h055, 10'h100, 2'h1, 16'hFFAB, 1'b0);
		rq(edc_pkg::EDC_OP_WRITE, 12'h055, 10'h100, 2'h2, 16'hCDFF, 1'b1);
		rq(edc_pkg::EDC_OP_READ, 12'h055, 10'h100, 2'h3, 16'h0000, 1'b0);
		chk("byte merge", 16'hCDAB, rd);
		rq(edc_pkg::EDC_OP_READ, 12'h055, 10'h100, 2'h1, 16'h0000, 1'b0);
		chk("lower byte read", 16'h00AB, {8'h00, rd[7:0]});
		rq(edc_pkg::EDC_OP_READ, 12'h055, 10'h100, 2'h2, 16'h0000, 1'b1);
		chk("upper byte read", 16'h00CD, {8'h00, rd[15:8]});
	endtask : t_bytes
	task automatic t_rmw();
		rq(edc_pkg::EDC_OP_RMW, 12'h055, 10'h100, 2'h3, 16'h7E81, 1'b1);
		chk("read-write old", 16'hCDAB, rd);
		rq(edc_pkg::EDC_OP_READ, 12'h055, 10'h100, 2'h3, 16'h0000, 1'b1);
		chk("read-write new", 16'h7E81, rd);
	endtask : t_rmw
	// Idle stretch must still see periodic refresh, and data must survive it
	task automatic t_refresh();
		int c0;
		c0 = cbr_count;
		repeat (400) @(negedge clk_sys);
		chk_min("refresh count", c0 + 5, cbr_count);
		rq(edc_pkg::EDC_OP_READ, 12'h123, 10'h000, 2'h3, 16'h0000, 1'b1);
		chk("data after refresh", 16'hA5C3, rd);
	endtask : t_refresh
	initial begin
		repeat (3) @(negedge clk_sys);
		t_reset();
		rstn = 1'b1;
		t_init();
		t_page();
		t_rows();
		t_bytes();
		t_rmw();
		t_refresh();
		chk("protocol faults", 16'h0000, violations[15:0]);
		end_of_test();
	end
endmodule : edc_controller_tb_top
